/* File: design/rst_ctrl_pkg.sv */
// rst_ctrl_pkg: constants and types shared by the reset controller files
// assumes one 200 MHz system clock and plain level inputs from every reset source
package rst_ctrl_pkg;

  // source positions in the request and cause vectors
  localparam int NUM_SRC = 10;
  localparam int SRC_POR = 0;
  localparam int SRC_PIN = 1;
  localparam int SRC_CMP = 2;
  localparam int SRC_SW = 3;
  localparam int SRC_SUPPLY = 4;
  localparam int SRC_WDOG = 5;
  localparam int SRC_MCD = 6;
  localparam int SRC_FLASH = 7;
  localparam int SRC_WAKE_ALARM = 8;
  localparam int SRC_WAKE_FAIL = 9;

  // sources that no enable input can switch off
  localparam logic [NUM_SRC-1:0] ALWAYS_ON_MASK = 10'h08B;
  // cause flags after power-up of the controller itself
  localparam logic [NUM_SRC-1:0] CAUSE_RESET = 10'h001;

  // port pin defaults while in reset
  localparam int NUM_PINS = 24;
  localparam logic PORT_LATCH_RESET = 1'b1;
  localparam logic PORT_OD_RESET = 1'b1;

  // restart point of the core
  localparam int PC_W = 16;
  localparam logic [PC_W-1:0] RESET_VECTOR = 16'h0000;

  // clock defaults after reset: low power oscillator divided by eight
  localparam int LPO_FREQ_MHZ = 20;
  localparam int CLK_DIV_RESET_RATIO = 8;
  localparam logic [2:0] CLK_DIV_RESET_CODE = 3'($clog2(CLK_DIV_RESET_RATIO));

  // timeout monitor restarts with its longest interval
  localparam int WDOG_INTERVAL_W = 8;
  localparam logic [WDOG_INTERVAL_W-1:0] WDOG_INTERVAL_MAX = 8'hFF;

  // least time reset stays asserted after the last source drops
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MIN_HOLD_NS = 100;
  localparam int MIN_HOLD_CYCLES = (MIN_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    CLK_LOW_POWER_OSC,
    CLK_PRECISION_OSC,
    CLK_EXTERNAL,
    CLK_CRYSTAL_32K
  } clk_src_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_HOLD,
    ST_RELEASE
  } seq_state_t;

endpackage

/* File: design/rst_source_gather.sv */
// rst_source_gather: merges the reset sources and keeps a record of the causes
// assumes sources are levels synchronous to mclk_i; rst_i is the power-up reset
`timescale 1ns/1ps
`default_nettype none
module rst_source_gather
  import rst_ctrl_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // sources and their enables
  input wire logic [NUM_SRC-1:0] src_i,
  input wire logic [NUM_SRC-1:0] src_en_i,
  // sequencer phase
  input wire logic entry_i,
  input wire logic hold_i,
  // merged request and cause record
  output logic req_o,
  output logic [NUM_SRC-1:0] req_vec_o,
  output logic [NUM_SRC-1:0] cause_o
);

  typedef struct packed {
    logic [NUM_SRC-1:0] cause;
  } gather_t;

  gather_t st;
  gather_t next_st;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      assign req_vec_o[g] = src_i[g] & (src_en_i[g] | ALWAYS_ON_MASK[g]);
    end
  endgenerate

  assign req_o = |req_vec_o;

  // a new reset replaces the record; sources seen while held are added
  always_comb begin
    next_st = st;
    if (entry_i) begin
      next_st.cause = req_vec_o;
    end else if (hold_i) begin
      next_st.cause = st.cause | req_vec_o;
    end
  end

  // the record survives every reset except power-up of this logic
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st.cause <= CAUSE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign cause_o = st.cause;

endmodule
`default_nettype wire

/* File: design/port_reset_drive.sv */
// port_reset_drive: forces each port pin to its safe state during reset
// assumes in_reset_i is the registered-to-be reset phase from the sequencer
`timescale 1ns/1ps
`default_nettype none
module port_reset_drive
  import rst_ctrl_pkg::*;
#(
  parameter int N_PINS = NUM_PINS
)
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // control
  input wire logic in_reset_i,
  input wire logic [N_PINS-1:0] pullup_dis_i,
  // pin forcing
  output logic [N_PINS-1:0] latch_one_o,
  output logic [N_PINS-1:0] open_drain_o,
  output logic [N_PINS-1:0] pullup_en_o
);

  typedef struct packed {
    logic [N_PINS-1:0] latch;
    logic [N_PINS-1:0] od;
    logic [N_PINS-1:0] pullup_off;
  } pins_t;

  pins_t st;
  pins_t next_st;

  // per pin: reset forces latch high, open-drain, pull-up on
  always_comb begin
    next_st = st;
    for (int i = 0; i < N_PINS; i++) begin
      next_st.latch[i] = in_reset_i ? PORT_LATCH_RESET : 1'b0;
      next_st.od[i] = in_reset_i ? PORT_OD_RESET : 1'b0;
      if (in_reset_i) begin
        next_st.pullup_off[i] = 1'b0;
      end else if (pullup_dis_i[i]) begin
        next_st.pullup_off[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st.latch <= {N_PINS{PORT_LATCH_RESET}};
      st.od <= {N_PINS{PORT_OD_RESET}};
      st.pullup_off <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign latch_one_o = st.latch;
  assign open_drain_o = st.od;
  assign pullup_en_o = ~st.pullup_off;

endmodule
`default_nettype wire

/* File: design/system_reset_controller.sv */
// system_reset_controller: gathers reset sources into one system reset and
// sequences halt, defaults and restart of the core
// assumes all inputs synchronous to mclk_i; rst_i marks power-up of this logic
// What this block does
// - halt the core while reset is held
// - reset registers, except power-on-only bits
// - port latches one, pins open-drain
// - weak pull-ups on during and after reset
// - reset disables interrupts and timers
// - data memory kept across reset
// - drive reset pin low for power/supply resets
// - restart fetching at address zero
// - clock returns to internal oscillator
// - timeout monitor enabled after release
// - ten reset sources enter reset
// - wake clock alarm and failure both reset
// - clock is low-power oscillator divided by eight
// - timeout reset leaves pin; longest interval
`timescale 1ns/1ps
`default_nettype none
module system_reset_controller
  import rst_ctrl_pkg::*;
#(
  parameter int N_PINS = NUM_PINS,
  parameter int HOLD_CYCLES = MIN_HOLD_CYCLES
)
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // reset sources, active high except the pin
  input wire logic por_i,
  input wire logic reset_pin_n_i,
  input wire logic comparator_rst_i,
  input wire logic sw_rst_req_i,
  input wire logic supply_mon_rst_i,
  input wire logic timeout_monitor_ovf_i,
  input wire logic missing_clock_i,
  input wire logic flash_err_i,
  input wire logic wake_clock_unit_alarm_i,
  input wire logic wake_clock_unit_fail_i,
  input wire logic [NUM_SRC-1:0] src_en_i,
  // run-time settings from the core
  input wire logic clk_req_i,
  input wire logic [1:0] clk_sel_req_i,
  input wire logic [2:0] clk_div_req_i,
  input wire logic timeout_monitor_dis_i,
  input wire logic [N_PINS-1:0] port_pullup_dis_i,
  // system reset
  output logic core_halt_o,
  output logic module_rst_o,
  output logic por_rst_o,
  output logic irq_disable_o,
  output logic timer_disable_o,
  output logic ram_write_block_o,
  output logic [NUM_SRC-1:0] reset_cause_o,
  // core restart
  output logic [PC_W-1:0] program_counter_o,
  output logic pc_load_o,
  // clock defaults
  output logic [1:0] clk_sel_o,
  output logic [2:0] clk_div_o,
  // timeout monitor
  output logic timeout_monitor_en_o,
  output logic timeout_monitor_restart_o,
  output logic [WDOG_INTERVAL_W-1:0] timeout_monitor_interval_o,
  // reset pin, open-drain
  output logic reset_pin_n_o,
  output logic reset_pin_n_oe_o,
  // port pins
  output logic [N_PINS-1:0] port_latch_o,
  output logic [N_PINS-1:0] port_open_drain_o,
  output logic [N_PINS-1:0] port_pullup_en_o
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CYCLES - 1);

  typedef struct packed {
    seq_state_t state;
    logic [CW-1:0] cnt;
    logic halt;
    logic mod_rst;
    logic por_rst;
    logic irq_dis;
    logic tmr_dis;
    logic drive_pin;
    logic [PC_W-1:0] pc;
    logic pc_load;
    clk_src_t clk_sel;
    logic [2:0] clk_div;
    logic wdog_en;
    logic wdog_restart;
    logic [WDOG_INTERVAL_W-1:0] wdog_interval;
  } seq_t;

  seq_t st;
  seq_t next_st;
  logic [NUM_SRC-1:0] src_vec;
  logic [NUM_SRC-1:0] en_vec;
  logic [NUM_SRC-1:0] req_vec;
  logic any_req;
  logic entry;
  logic pin_masked;

  // the pin reads back our own drive, so it is ignored while we pull it low
  assign pin_masked = st.drive_pin | (st.state == ST_RELEASE);

  always_comb begin
    src_vec = '0;
    src_vec[SRC_POR] = por_i;
    src_vec[SRC_PIN] = ~reset_pin_n_i & ~pin_masked;
    src_vec[SRC_CMP] = comparator_rst_i;
    src_vec[SRC_SW] = sw_rst_req_i;
    src_vec[SRC_SUPPLY] = supply_mon_rst_i;
    src_vec[SRC_WDOG] = timeout_monitor_ovf_i & st.wdog_en;
    src_vec[SRC_MCD] = missing_clock_i;
    src_vec[SRC_FLASH] = flash_err_i;
    src_vec[SRC_WAKE_ALARM] = wake_clock_unit_alarm_i;
    src_vec[SRC_WAKE_FAIL] = wake_clock_unit_fail_i;
  end

  // overflow is only a source while the monitor is running
  always_comb begin
    en_vec = src_en_i;
    en_vec[SRC_WDOG] = 1'b1;
  end

  assign entry = (st.state == ST_RUN) & any_req;

  rst_source_gather u_gather (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .src_i(src_vec),
    .src_en_i(en_vec),
    .entry_i(entry),
    .hold_i(st.state != ST_RUN),
    .req_o(any_req),
    .req_vec_o(req_vec),
    .cause_o(reset_cause_o)
  );

  // sequencer: run, hold while any source, then a fixed release delay
  always_comb begin
    next_st = st;
    next_st.pc_load = 1'b0;
    next_st.wdog_restart = 1'b0;
    case (st.state)
      ST_RUN: begin
        if (any_req) begin
          next_st.state = ST_HOLD;
          next_st.halt = 1'b1;
          next_st.mod_rst = 1'b1;
          next_st.por_rst = req_vec[SRC_POR];
          next_st.irq_dis = 1'b1;
          next_st.tmr_dis = 1'b1;
          next_st.drive_pin = req_vec[SRC_POR] | req_vec[SRC_SUPPLY];
          next_st.pc = RESET_VECTOR;
        end else begin
          if (clk_req_i) begin
            next_st.clk_sel = clk_src_t'(clk_sel_req_i);
            next_st.clk_div = clk_div_req_i;
          end
          if (timeout_monitor_dis_i) begin
            next_st.wdog_en = 1'b0;
          end
        end
      end
      ST_HOLD, ST_RELEASE: begin
        next_st.por_rst = st.por_rst | req_vec[SRC_POR];
        next_st.drive_pin = st.drive_pin | req_vec[SRC_POR] | req_vec[SRC_SUPPLY];
        if (any_req) begin
          next_st.state = ST_HOLD;
          next_st.cnt = '0;
        end else if (st.state == ST_HOLD) begin
          next_st.state = ST_RELEASE;
          next_st.cnt = '0;
        end else if (st.cnt == HOLD_LAST) begin
          next_st.state = ST_RUN;
          next_st.halt = 1'b0;
          next_st.mod_rst = 1'b0;
          next_st.por_rst = 1'b0;
          next_st.irq_dis = 1'b0;
          next_st.tmr_dis = 1'b0;
          next_st.drive_pin = 1'b0;
          next_st.pc = RESET_VECTOR;
          next_st.pc_load = 1'b1;
          next_st.clk_sel = CLK_LOW_POWER_OSC;
          next_st.clk_div = CLK_DIV_RESET_CODE;
          next_st.wdog_en = 1'b1;
          next_st.wdog_restart = 1'b1;
          next_st.wdog_interval = WDOG_INTERVAL_MAX;
        end else begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end
      default: begin
        next_st.state = ST_HOLD;
      end
    endcase
  end

  // power-up of this logic behaves as a power-on reset already in hold
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st.state <= ST_HOLD;
      st.cnt <= '0;
      st.halt <= 1'b1;
      st.mod_rst <= 1'b1;
      st.por_rst <= 1'b1;
      st.irq_dis <= 1'b1;
      st.tmr_dis <= 1'b1;
      st.drive_pin <= 1'b1;
      st.pc <= RESET_VECTOR;
      st.pc_load <= 1'b0;
      st.clk_sel <= CLK_LOW_POWER_OSC;
      st.clk_div <= CLK_DIV_RESET_CODE;
      st.wdog_en <= 1'b1;
      st.wdog_restart <= 1'b0;
      st.wdog_interval <= WDOG_INTERVAL_MAX;
    end else begin
      st <= next_st;
    end
  end

  // pins follow the next halt so they change in the same cycle as core_halt_o
  port_reset_drive #(
    .N_PINS(N_PINS)
  ) u_ports (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .in_reset_i(next_st.halt),
    .pullup_dis_i(port_pullup_dis_i),
    .latch_one_o(port_latch_o),
    .open_drain_o(port_open_drain_o),
    .pullup_en_o(port_pullup_en_o)
  );

  // output mapping
  assign core_halt_o = st.halt;
  assign module_rst_o = st.mod_rst;
  assign por_rst_o = st.por_rst;
  assign irq_disable_o = st.irq_dis;
  assign timer_disable_o = st.tmr_dis;
  assign ram_write_block_o = st.halt;
  assign program_counter_o = st.pc;
  assign pc_load_o = st.pc_load;
  assign clk_sel_o = st.clk_sel;
  assign clk_div_o = st.clk_div;
  assign timeout_monitor_en_o = st.wdog_en;
  assign timeout_monitor_restart_o = st.wdog_restart;
  assign timeout_monitor_interval_o = st.wdog_interval;
  assign reset_pin_n_o = 1'b0;
  assign reset_pin_n_oe_o = st.drive_pin;

  // checks on the sequencer
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_entry_halts: assert property (entry |=> core_halt_o && module_rst_o)
    else $error("reset entry did not halt core");
  a_entry_disables: assert property (entry |=> irq_disable_o && timer_disable_o)
    else $error("interrupts or timers not disabled");
  a_por_only_bits: assert property (por_rst_o |-> module_rst_o && reset_cause_o[SRC_POR])
    else $error("power-on-only reset without power-on cause");
  a_ports_safe: assert property (core_halt_o |-> &port_latch_o && &port_open_drain_o)
    else $error("port pins not forced in reset");
  a_pullup_kept: assert property ($fell(core_halt_o) |-> &port_pullup_en_o)
    else $error("pull-ups off at release");
  a_ram_kept: assert property (core_halt_o |-> ram_write_block_o)
    else $error("memory writable during reset");
  a_pin_cause: assert property (reset_pin_n_oe_o |-> core_halt_o
      && (reset_cause_o[SRC_POR] || reset_cause_o[SRC_SUPPLY]))
    else $error("reset pin driven without power cause");
  // a disabled supply monitor may stand high while another source enters reset
  a_pin_driven: assert property (entry && req_vec[SRC_SUPPLY] |=> reset_pin_n_oe_o[*2])
    else $error("supply reset did not drive pin");
  a_restart_zero: assert property ($fell(core_halt_o) |->
      pc_load_o && program_counter_o == RESET_VECTOR)
    else $error("restart not at address zero");
  a_clk_default: assert property ($fell(core_halt_o) |->
      clk_sel_o == CLK_LOW_POWER_OSC && clk_div_o == CLK_DIV_RESET_CODE)
    else $error("clock not back on low power oscillator");
  a_wdog_restart: assert property ($fell(core_halt_o) |-> timeout_monitor_en_o
      && timeout_monitor_restart_o && timeout_monitor_interval_o == WDOG_INTERVAL_MAX)
    else $error("timeout monitor not restarted");
  a_wdog_no_pin: assert property (entry && req_vec == (NUM_SRC'(1) << SRC_WDOG)
      |=> !reset_pin_n_oe_o)
    else $error("timeout reset drove the pin");
  // both wake clock events are gated by their own enables
  a_wake_sources: assert property (!core_halt_o && !pin_masked
      && ((wake_clock_unit_alarm_i && src_en_i[SRC_WAKE_ALARM])
      || (wake_clock_unit_fail_i && src_en_i[SRC_WAKE_FAIL])) |=> core_halt_o)
    else $error("wake clock event missed");
  a_held_active: assert property (core_halt_o && any_req |=> core_halt_o)
    else $error("released while a source active");
  a_min_hold: assert property ($rose(st.state == ST_RELEASE) && !any_req
      |-> core_halt_o[*2])
    else $error("release delay too short");
  // written from the pins, not from the gathered vector, so a gating slip shows
  a_any_source: assert property (!core_halt_o && (por_i || sw_rst_req_i || flash_err_i
      || (comparator_rst_i && src_en_i[SRC_CMP])
      || (supply_mon_rst_i && src_en_i[SRC_SUPPLY])
      || (missing_clock_i && src_en_i[SRC_MCD])) |=> core_halt_o)
    else $error("enabled source ignored");

  c_por_cycle: cover property (entry && por_i ##1 reset_pin_n_oe_o ##[1:100] $fell(core_halt_o));
  c_wdog_cycle: cover property (entry && timeout_monitor_ovf_i ##[1:100] pc_load_o);
  c_reentry: cover property (st.state == ST_RELEASE && any_req ##1 st.state == ST_HOLD);

endmodule
`default_nettype wire

/* File: testbench/reset_source_model.sv */
// reset_source_model: far side of the reset controller, the sources and the reset pin
// assumes the bench commands each source as a level through req_i
`timescale 1ns/1ps
`default_nettype none
module reset_source_model
  import rst_ctrl_pkg::*;
(
  // commands from the bench
  input wire logic [NUM_SRC-1:0] req_i,
  // reset pin as driven by the controller
  input wire logic pin_drive_i,
  input wire logic pin_oe_i,
  // levels seen by the controller
  output logic [NUM_SRC-1:0] src_o,
  output logic pin_level_o
);
  // every source is raised on command
  assign src_o = req_i;
  // pin has a pull-up, so a released pin reads high, never a held value
  assign pin_level_o = ~(pin_oe_i & ~pin_drive_i) & ~req_i[SRC_PIN];
endmodule
`default_nettype wire

/* File: testbench/system_reset_controller_bench.sv */
// system_reset_controller_bench: random and directed checks of the reset sequencer
// assumes the controller is built with a short hold count to keep the run brief
`timescale 1ns/1ps
`default_nettype none
module system_reset_controller_bench
  import rst_ctrl_pkg::*;
;
  localparam int HOLD = 2;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [NUM_SRC-1:0] req = '0;
  logic [NUM_SRC-1:0] src;
  logic [NUM_SRC-1:0] en = '1;
  logic clk_req = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [2:0] div = 3'h0;
  logic wd_dis = 1'b0;
  logic [NUM_PINS-1:0] pu_dis = '0;
  logic [NUM_PINS-1:0] pu_val;
  logic pin_level, halt, mrst, porr, irqd, tmrd, ramb, pcl, wen, wrs, pin_d, pin_oe;
  logic [NUM_SRC-1:0] cause;
  logic [PC_W-1:0] pc;
  logic [1:0] csel;
  logic [2:0] cdiv;
  logic [7:0] wint;
  logic [NUM_PINS-1:0] latch, od, pu;
  logic [31:0] rng = 32'h0000002A;
  int n_errors = 0;
  int num_checks = 0;
  int len;

  // clock at 200 MHz
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  reset_source_model partner (.req_i(req), .pin_drive_i(pin_d), .pin_oe_i(pin_oe),
    .src_o(src), .pin_level_o(pin_level));

  system_reset_controller #(.N_PINS(NUM_PINS), .HOLD_CYCLES(HOLD)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .por_i(src[SRC_POR]), .reset_pin_n_i(pin_level),
    .comparator_rst_i(src[SRC_CMP]), .sw_rst_req_i(src[SRC_SW]),
    .supply_mon_rst_i(src[SRC_SUPPLY]), .timeout_monitor_ovf_i(src[SRC_WDOG]),
    .missing_clock_i(src[SRC_MCD]), .flash_err_i(src[SRC_FLASH]),
    .wake_clock_unit_alarm_i(src[SRC_WAKE_ALARM]), .wake_clock_unit_fail_i(src[SRC_WAKE_FAIL]),
    .src_en_i(en), .clk_req_i(clk_req), .clk_sel_req_i(sel), .clk_div_req_i(div),
    .timeout_monitor_dis_i(wd_dis), .port_pullup_dis_i(pu_dis), .core_halt_o(halt),
    .module_rst_o(mrst), .por_rst_o(porr), .irq_disable_o(irqd), .timer_disable_o(tmrd),
    .ram_write_block_o(ramb), .reset_cause_o(cause), .program_counter_o(pc),
    .pc_load_o(pcl), .clk_sel_o(csel), .clk_div_o(cdiv), .timeout_monitor_en_o(wen),
    .timeout_monitor_restart_o(wrs), .timeout_monitor_interval_o(wint),
    .reset_pin_n_o(pin_d), .reset_pin_n_oe_o(pin_oe), .port_latch_o(latch),
    .port_open_drain_o(od), .port_pullup_en_o(pu));

  // xorshift generator, fixed start so runs repeat
  function logic [31:0] next_rand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // only power-on and supply resets pull the pin
  function logic exp_oe(int s);
    return (s == SRC_POR) || (s == SRC_SUPPLY);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  // inputs move 1 ns after the edge, outputs are read there too
  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge mclk_i);
      #1;
    end
  endtask

  task automatic check_held(input int s, input logic [NUM_SRC-1:0] c);
    chk(halt, 1'b1);
    chk(mrst, 1'b1);
    chk(porr, s == SRC_POR);
    chk({irqd, tmrd}, 2'h3);
    chk(ramb, 1'b1);
    chk(latch, {NUM_PINS{PORT_LATCH_RESET}});
    chk(od, {NUM_PINS{PORT_OD_RESET}});
    chk(pu, {NUM_PINS{1'b1}});
    chk(pin_oe, exp_oe(s));
    chk(pin_d, 1'b0);
    chk(cause, c);
  endtask

  // counts edges from the drop of the last source to the restart of the core
  task automatic wait_run(input int edges);
    int c;
    c = 0;
    do begin
      tick();
      c++;
    end while (halt !== 1'b0 && c < 60);
    chk(c, edges);
    chk({pcl, wrs}, 2'h3);
    chk(pc, RESET_VECTOR);
    chk(csel, CLK_LOW_POWER_OSC);
    chk(cdiv, CLK_DIV_RESET_CODE);
    chk({wen, wint}, {1'b1, WDOG_INTERVAL_MAX});
    chk({latch, pin_oe}, '0);
    chk(od, '0);
    chk({mrst, porr, irqd, tmrd, ramb}, '0);
    tick();
    chk({pcl, wrs}, 2'h0);
  endtask

  task close_out();
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard, well beyond the roughly 140 cycles the tests take
  initial begin
    #20000;
    n_errors++;
    close_out();
  end

  initial begin
    tick(6);
    check_held(SRC_POR, CAUSE_RESET);
    rst_i = 1'b0;
    wait_run(HOLD + 1);
    // every source in turn, after moving clock and pull-up away from defaults
    for (int s = 0; s < NUM_SRC; s++) begin
      sel = 2'(next_rand());
      div = 3'(next_rand());
      clk_req = 1'b1;
      tick();
      clk_req = 1'b0;
      chk({csel, cdiv}, {sel, div});
      pu_dis = NUM_PINS'(next_rand());
      pu_val = ~pu_dis;
      tick();
      pu_dis = '0;
      tick();
      chk(pu, pu_val);
      len = 2 + next_rand() % 3;
      req[s] = 1'b1;
      tick();
      check_held(s, NUM_SRC'(1) << s);
      tick(len - 1);
      req[s] = 1'b0;
      wait_run(HOLD + 1);
    end
    // gated sources with their enable off are ignored
    for (int b = 0; b < NUM_SRC; b++) begin
      if (!ALWAYS_ON_MASK[b] && b != SRC_WDOG) begin
        en[b] = 1'b0;
        req[b] = 1'b1;
        tick(2);
        chk(halt, 1'b0);
        req[b] = 1'b0;
        en[b] = 1'b1;
      end
    end
    // overflow ignored once the monitor is switched off
    wd_dis = 1'b1;
    tick();
    wd_dis = 1'b0;
    chk(wen, 1'b0);
    req[SRC_WDOG] = 1'b1;
    tick(2);
    chk(halt, 1'b0);
    req[SRC_WDOG] = 1'b0;
    // a second source during the release delay restarts it; clock requests while halted are ignored
    req[SRC_SW] = 1'b1;
    tick(2);
    req[SRC_SW] = 1'b0;
    clk_req = 1'b1;
    sel = 2'h2;
    tick();
    clk_req = 1'b0;
    chk(csel, CLK_LOW_POWER_OSC);
    req[SRC_FLASH] = 1'b1;
    tick(2);
    req[SRC_FLASH] = 1'b0;
    chk(cause, (NUM_SRC'(1) << SRC_SW) | (NUM_SRC'(1) << SRC_FLASH));
    wait_run(HOLD + 1);
    // reset of this logic in mid-run
    rst_i = 1'b1;
    tick();
    check_held(SRC_POR, CAUSE_RESET);
    rst_i = 1'b0;
    wait_run(HOLD + 1);
    close_out();
  end
endmodule
`default_nettype wire
